//--- pkg/timer_pwm_pkg.sv
/*
 Shared constants for the PWM / capture timer: register offsets, field
 positions, reset values and mode codes.
 Assumes an AXI4-Lite slave with 32-bit data and word-aligned registers.
*/
package timer_pwm_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL_FIRST  = 8'h00;
  localparam logic [7:0] OFF_CTRL_SECOND = 8'h04;
  localparam logic [7:0] OFF_COUNT       = 8'h08;
  localparam logic [7:0] OFF_RELOAD      = 8'h0C;
  localparam logic [7:0] OFF_PWM         = 8'h10;
  localparam logic [7:0] OFF_DEADBAND    = 8'h14;
  localparam logic [7:0] OFF_STATUS      = 8'h18;

  // First control register fields
  localparam int BIT_ENABLE       = 0;
  localparam int BIT_POLARITY     = 1;
  localparam int BIT_MODE_HI      = 2;
  localparam int POS_INT_SRC      = 4;
  localparam int BIT_CAPTURE_FLAG = 7;
  // Second control register fields
  localparam int POS_MODE   = 0;
  localparam int POS_PRESCL = 8;

  // Mode codes: {high bit, 3-bit field}
  localparam logic [3:0] MODE_PWM_SINGLE = 4'h3;
  localparam logic [3:0] MODE_CAPTURE    = 4'h4;
  localparam logic [3:0] MODE_PWM_DUAL   = 4'h8;

  // Interrupt source select codes
  localparam logic [1:0] INT_SRC_BOTH    = 2'h0;
  localparam logic [1:0] INT_SRC_CAPTURE = 2'h2;
  localparam logic [1:0] INT_SRC_RELOAD  = 2'h3;

  localparam logic [15:0] COUNT_RESTART = 16'h0001;
  localparam logic [15:0] COUNT_RESET   = 16'h0001;
  localparam logic [15:0] RELOAD_RESET  = 16'hFFFF;
  localparam logic [15:0] PWM_RESET     = 16'h0000;
  localparam logic [7:0]  DEADBAND_MAX  = 8'h80;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;
endpackage

//--- core/dead_band_delay.sv
/*
 Delays the rising edge of one output by a programmed number of cycles;
 falling edges pass at once.
 Assumes clk and synchronous active-high rst shared with the timer.
*/
`timescale 1ns/1ps
`default_nettype none
module dead_band_delay #(
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          bypass,
  input  wire logic [DW-1:0] delay,
  input  wire logic          levelIn,
  output logic               levelOut
);
  // The wait counter must reach the largest dead band of 128
  if (DW < 8) begin : gBadWidth
    $error("dead_band_delay: counter too narrow");
  end

  logic [DW-1:0] waitCnt_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      waitCnt_r <= '0;
    end else if (!levelIn) begin
      waitCnt_r <= '0;
    end else if (waitCnt_r != delay) begin
      waitCnt_r <= waitCnt_r + 1'b1;
    end
  end

  // Output held low until the wait elapses; a zero delay rises at once
  always_ff @(posedge clk) begin
    if (rst) begin
      levelOut <= 1'b0;
    end else if (bypass) begin
      levelOut <= levelIn;
    end else begin
      levelOut <= levelIn && (waitCnt_r == delay);
    end
  end
endmodule
`default_nettype wire

//--- core/timer_pwm_capture.sv
/*
 Timer with PWM single, PWM dual (with dead band) and capture modes,
 registers on an AXI4-Lite slave.
 Assumes timerIn synchronous to clk; pin muxing outside follows pinIsOutput.
*/
// Operation
// - PWM modes: count up, toggle output when counter equals match value.
// - At reload in PWM modes: interrupt event, counter to 0001H, keep counting.
// - Polarity one: output starts high, low at match, high again at reload.
// - Polarity zero: output starts low, high at match, low again at reload.
// - Loaded start count only shapes first period; later periods start at 0001H.
// - Dual mode drives second pin with the inverse of the primary output.
// - Dual mode delays each rising edge by dead band of 0..128 cycles.
// - Dual mode turns the shared input pin into the complementary output.
// - Mode comes from second-register field plus high bit of first register.
// - Capture mode copies counter into match register on selected edge.
// - Capture event: interrupt event, set capture flag, counter keeps running.
// - Capture mode reload: interrupt event, clear capture flag, keep counting.
// - Interrupt source field selects both, capture only or reload only.
`timescale 1ns/1ps
`default_nettype none
module timer_pwm_capture
  import timer_pwm_pkg::*;
#(
  parameter int CW = 16,
  parameter int PW = 8
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        timerIn,
  output logic             timerOut,
  output logic             timerOutComp,
  output logic             pinIsOutput,
  output logic             timerEvent
);
  if (CW != 16 || PW < 1 || PW > 8) begin : gBadWidth
    $error("timer_pwm_capture: unsupported widths");
  end

  logic          enable_r;
  logic          polarity_r;
  logic          modeHi_r;
  logic [1:0]    intSrc_r;
  logic          capFlag_r;
  logic [2:0]    modeField_r;
  logic [PW-1:0] prescale_r;
  logic [CW-1:0] count_r;
  logic [CW-1:0] reload_r;
  logic [CW-1:0] match_r;
  logic [7:0]    deadBand_r;
  logic [PW-1:0] preCnt_r;
  logic          pwmLevel_r;
  logic          inPrev_r;
  logic          awTaken_r;
  logic          wTaken_r;
  logic [7:0]    awAddr_r;
  logic [31:0]   wData_r;
  logic [3:0]    wStrb_r;
  logic          primaryDly;
  logic          compDly;

  typedef enum logic [2:0] {
    MD_IDLE = 3'b001,
    MD_PWM  = 3'b010,
    MD_CAP  = 3'b100
  } run_t;
  run_t run;

  logic [3:0] modeCode;
  assign modeCode = {modeHi_r, modeField_r};
  logic isDual;
  assign isDual = (modeCode == MODE_PWM_DUAL);

  always_comb begin
    case (modeCode)
      MODE_PWM_SINGLE, MODE_PWM_DUAL: run = MD_PWM;
      MODE_CAPTURE:                   run = MD_CAP;
      default:                        run = MD_IDLE;
    endcase
  end

  // Byte-lane merge used by every writable register except the dead band register, which takes wData_r[7:0] whole
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[8*i +: 8] = nw[8*i +: 8];
    end
    return res;
  endfunction

  // Prescaler of value 0 behaves as 1
  logic tick;
  assign tick = enable_r && (run != MD_IDLE) &&
                (preCnt_r + 1'b1 >= prescale_r || prescale_r == '0);

  always_ff @(posedge clk) begin
    if (rst || !enable_r || tick) begin
      preCnt_r <= '0;
    end else begin
      preCnt_r <= preCnt_r + 1'b1;
    end
  end

  logic atReload;
  logic atMatch;
  logic capEdge;
  assign atReload = tick && (count_r == reload_r);
  assign atMatch  = tick && (count_r == match_r) && (run == MD_PWM);
  // Edge chosen by polarity: one selects rising, zero falling
  assign capEdge  = enable_r && (run == MD_CAP) && (inPrev_r != timerIn) &&
                    (timerIn == polarity_r);

  always_ff @(posedge clk) begin
    if (rst) begin
      inPrev_r <= 1'b0;
    end else begin
      inPrev_r <= timerIn;
    end
  end

  // Bus write handshake: address and data in either order
  logic wrFire;
  assign wrFire = awTaken_r && wTaken_r && !s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (rst) begin
      awTaken_r <= 1'b0;
      wTaken_r  <= 1'b0;
      awAddr_r  <= 8'h00;
      wData_r   <= 32'h0000_0000;
      wStrb_r   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awTaken_r <= 1'b1;
        awAddr_r  <= s_axi_awaddr;
      end else if (wrFire) begin
        awTaken_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wTaken_r <= 1'b1;
        wData_r  <= s_axi_wdata;
        wStrb_r  <= s_axi_wstrb;
      end else if (wrFire) begin
        wTaken_r <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !awTaken_r && !s_axi_bvalid;
  assign s_axi_wready  = !wTaken_r && !s_axi_bvalid;

  logic addrOk;
  assign addrOk = (awAddr_r <= OFF_STATUS) && (awAddr_r[1:0] == 2'b00);

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addrOk ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic wrCtl0;
  logic wrCtl1;
  logic wrCount;
  logic wrReload;
  logic wrPwm;
  logic wrDead;
  logic [31:0] wMerged;
  assign wrCtl0   = wrFire && awAddr_r == OFF_CTRL_FIRST;
  assign wrCtl1   = wrFire && awAddr_r == OFF_CTRL_SECOND;
  assign wrCount  = wrFire && awAddr_r == OFF_COUNT;
  assign wrReload = wrFire && awAddr_r == OFF_RELOAD;
  assign wrPwm    = wrFire && awAddr_r == OFF_PWM;
  assign wrDead   = wrFire && awAddr_r == OFF_DEADBAND;

  logic [31:0] ctl0Read;
  assign ctl0Read = {24'h00_0000, capFlag_r, 1'b0, intSrc_r, 1'b0, modeHi_r, polarity_r,
                     enable_r};
  assign wMerged = merge(ctl0Read, wData_r, wStrb_r);

  always_ff @(posedge clk) begin
    if (rst) begin
      enable_r   <= 1'b0;
      polarity_r <= 1'b0;
      modeHi_r   <= 1'b0;
      intSrc_r   <= INT_SRC_BOTH;
    end else if (wrCtl0) begin
      enable_r   <= wMerged[BIT_ENABLE];
      polarity_r <= wMerged[BIT_POLARITY];
      modeHi_r   <= wMerged[BIT_MODE_HI];
      intSrc_r   <= wMerged[POS_INT_SRC +: 2];
    end
  end

  logic [31:0] ctl1Merged;
  assign ctl1Merged = merge({16'h0000, 8'(prescale_r), 5'h00, modeField_r}, wData_r, wStrb_r);

  always_ff @(posedge clk) begin
    if (rst) begin
      modeField_r <= 3'h0;
      prescale_r  <= PW'(1);
    end else if (wrCtl1) begin
      modeField_r <= ctl1Merged[POS_MODE +: 3];
      prescale_r  <= ctl1Merged[POS_PRESCL +: PW];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      deadBand_r <= 8'h00;
      reload_r   <= RELOAD_RESET;
    end else begin
      if (wrDead) begin
        deadBand_r <= (wData_r[7:0] > DEADBAND_MAX) ? DEADBAND_MAX : wData_r[7:0];
      end
      if (wrReload) begin
        reload_r <= 16'(merge({16'h0000, reload_r}, wData_r, wStrb_r));
      end
    end
  end

  // Counter: a software write wins; reload in PWM modes restarts at 0001H
  always_ff @(posedge clk) begin
    if (rst) begin
      count_r <= COUNT_RESET;
    end else if (wrCount) begin
      count_r <= 16'(merge({16'h0000, count_r}, wData_r, wStrb_r));
    end else if (atReload && run == MD_PWM) begin
      count_r <= COUNT_RESTART;
    end else if (tick) begin
      count_r <= count_r + 1'b1;
    end
  end

  // Match register doubles as capture register; capture beats a write
  always_ff @(posedge clk) begin
    if (rst) begin
      match_r <= PWM_RESET;
    end else if (capEdge) begin
      match_r <= count_r;
    end else if (wrPwm) begin
      match_r <= 16'(merge({16'h0000, match_r}, wData_r, wStrb_r));
    end
  end

  // Capture flag: capture sets, reload clears; set wins
  always_ff @(posedge clk) begin
    if (rst) begin
      capFlag_r <= 1'b0;
    end else if (capEdge) begin
      capFlag_r <= 1'b1;
    end else if (atReload && run == MD_CAP) begin
      capFlag_r <= 1'b0;
    end
  end

  // PWM level as "active" phase; polarity chooses output sense
  always_ff @(posedge clk) begin
    if (rst || !enable_r || run != MD_PWM) begin
      pwmLevel_r <= 1'b0;
    end else if (atReload) begin
      pwmLevel_r <= 1'b0;
    end else if (atMatch) begin
      pwmLevel_r <= 1'b1;
    end
  end

  logic primary;
  assign primary = pwmLevel_r ^ polarity_r;

  dead_band_delay #(.DW(8)) u_dly_main (
    .clk      (clk),
    .rst      (rst),
    .bypass   (!isDual),
    .delay    (deadBand_r),
    .levelIn  (primary),
    .levelOut (primaryDly)
  );

  dead_band_delay #(.DW(8)) u_dly_comp (
    .clk      (clk),
    .rst      (rst),
    .bypass   (!isDual),
    .delay    (deadBand_r),
    .levelIn  (!primary),
    .levelOut (compDly)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      timerOut     <= 1'b0;
      timerOutComp <= 1'b0;
      pinIsOutput  <= 1'b0;
    end else begin
      timerOut     <= primaryDly;
      timerOutComp <= isDual && compDly;
      pinIsOutput  <= isDual;
    end
  end

  // Event pulse filtered by interrupt source select
  logic capOk;
  logic relOk;
  assign capOk = (intSrc_r != INT_SRC_RELOAD);
  assign relOk = (intSrc_r != INT_SRC_CAPTURE);

  always_ff @(posedge clk) begin
    if (rst) begin
      timerEvent <= 1'b0;
    end else begin
      timerEvent <= (capEdge && capOk) || (atReload && run != MD_IDLE && relOk);
    end
  end

  // Read channel
  logic [31:0] rdMux;
  always_comb begin
    case (s_axi_araddr)
      OFF_CTRL_FIRST:  rdMux = ctl0Read;
      OFF_CTRL_SECOND: rdMux = {16'h0000, 8'(prescale_r), 5'h00, modeField_r};
      OFF_COUNT:       rdMux = {16'h0000, count_r};
      OFF_RELOAD:      rdMux = {16'h0000, reload_r};
      OFF_PWM:         rdMux = {16'h0000, match_r};
      OFF_DEADBAND:    rdMux = {24'h00_0000, deadBand_r};
      OFF_STATUS:      rdMux = {29'h0000_0000, pinIsOutput, timerOut, capFlag_r};
      default:         rdMux = 32'h0000_0000;
    endcase
  end

  logic rdOk;
  assign rdOk = (s_axi_araddr <= OFF_STATUS) && (s_axi_araddr[1:0] == 2'b00);
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdMux;
      s_axi_rresp  <= rdOk ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  property p_reload_restart;
    @(posedge clk) disable iff (rst)
    (atReload && run == MD_PWM && !wrCount) |=> (count_r == COUNT_RESTART);
  endproperty
  a_reload_restart: assert property (p_reload_restart) else $error("no restart at reload");

  property p_match_active;
    @(posedge clk) disable iff (rst)
    (atMatch && !atReload && enable_r) |=> pwmLevel_r;
  endproperty
  a_match_active: assert property (p_match_active) else $error("match did not toggle");

  property p_pol_high_start;
    @(posedge clk) disable iff (rst)
    (atReload && run == MD_PWM && polarity_r && !wrCtl0) |=> ##2 (timerOut || isDual);
  endproperty
  a_pol_high_start: assert property (p_pol_high_start) else $error("output not high");

  property p_pol_low_start;
    @(posedge clk) disable iff (rst)
    (atReload && run == MD_PWM && !polarity_r && !wrCtl0) |=> ##2 !timerOut;
  endproperty
  a_pol_low_start: assert property (p_pol_low_start) else $error("output not low");

  property p_comp_never_both;
    @(posedge clk) disable iff (rst)
    isDual |-> !(timerOut && timerOutComp);
  endproperty
  a_comp_never_both: assert property (p_comp_never_both) else $error("outputs overlap");

  property p_pin_switch;
    @(posedge clk) disable iff (rst)
    isDual |=> pinIsOutput;
  endproperty
  a_pin_switch: assert property (p_pin_switch) else $error("pin not switched");

  property p_capture_copy;
    @(posedge clk) disable iff (rst)
    capEdge |=> (match_r == $past(count_r)) && capFlag_r;
  endproperty
  a_capture_copy: assert property (p_capture_copy) else $error("capture lost");

  property p_capture_no_restart;
    @(posedge clk) disable iff (rst)
    (capEdge && tick && !wrCount && !atReload) |=> count_r == $past(count_r) + 16'h0001;
  endproperty
  a_capture_no_restart: assert property (p_capture_no_restart) else $error("restarted");

  property p_cap_reload_clear;
    @(posedge clk) disable iff (rst)
    (atReload && run == MD_CAP && !capEdge) |=> !capFlag_r;
  endproperty
  a_cap_reload_clear: assert property (p_cap_reload_clear) else $error("flag kept");

  property p_src_capture_only;
    @(posedge clk) disable iff (rst)
    (intSrc_r == INT_SRC_CAPTURE && !capEdge && !wrCtl0) |=> !timerEvent;
  endproperty
  a_src_capture_only: assert property (p_src_capture_only) else $error("wrong source");
endmodule
`default_nettype wire

//--- dv/gpio_pin_model.sv
/*
 Pin model for the shared timer input / complementary output pin.
 Assumes the bench drives levelIn while the timer leaves the pin as an input.
*/
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_model (
  input  wire logic levelIn,
  input  wire logic pinIsOutput,
  input  wire logic timerOutComp,
  output logic      timerIn
);
  // Outside driver lets go once the timer owns the pin
  assign timerIn = pinIsOutput ? timerOutComp : levelIn;
endmodule
`default_nettype wire

//--- dv/test_timer_pwm_capture.sv
/*
 Self-checking bench for the PWM / capture timer over AXI4-Lite.
 Assumes the pin model in gpio_pin_model and the package constants.
*/
`timescale 1ns/1ps
`default_nettype none
module test_timer_pwm_capture
  import timer_pwm_pkg::*;
;
  logic        clk = 0, rst = 1, pinLevel = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, timerIn;
  logic        timerOut, timerOutComp, pinIsOutput, timerEvent;
  int          n_errors = 0, checked = 0, nEv = 0, cyc = 0;

  timer_pwm_capture i_timer_pwm_capture (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .timerIn(timerIn), .timerOut(timerOut),
    .timerOutComp(timerOutComp), .pinIsOutput(pinIsOutput), .timerEvent(timerEvent));
  gpio_pin_model i_gpio_pin_model (.levelIn(pinLevel), .pinIsOutput(pinIsOutput),
    .timerOutComp(timerOutComp), .timerIn(timerIn));

  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (timerEvent === 1'b1) nEv <= nEv + 1;
  end

  task automatic conclude;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tout;
    n_errors++;
    $display("[ERR] t=%0t wait ran out got=%h exp=%h", $time, 0, 1);
    conclude;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aq, wq, sa, sw, got;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    aq = 1; wq = 1; got = 0;
    for (int k = 0; k < 50 && !got; k++) begin
      @(negedge clk);
      sa = aq && s_axi_ok(awready);
      sw = wq && s_axi_ok(wready);
      got = bvalid === 1'b1;
      r = bresp;
      @(posedge clk);
      if (sa) begin awvalid <= 0; aq = 0; end
      if (sw) begin wvalid <= 0; wq = 0; end
      if (got) bready <= 0;
    end
    if (!got) tout;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic aq, sa, got;
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1; aq = 1; got = 0;
    for (int k = 0; k < 50 && !got; k++) begin
      @(negedge clk);
      sa = aq && s_axi_ok(arready);
      got = rvalid === 1'b1;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (sa) begin arvalid <= 0; aq = 0; end
      if (got) rready <= 0;
    end
    if (!got) tout;
  endtask
  function automatic logic s_axi_ok(input logic v);
    return v === 1'b1;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    axr(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  // Disable first, enable as the very last write
  task automatic cfg(input logic [3:0] m, input logic pol, input int p, s, pw, db, rl,
                     input logic [1:0] src);
    logic [31:0] c0;
    c0 = {26'h0, src, 1'b0, m[3], pol, 1'b0};
    wr(OFF_CTRL_FIRST, c0);
    wr(OFF_CTRL_SECOND, {16'h0, p[7:0], 5'h0, m[2:0]});
    wr(OFF_COUNT, s);
    wr(OFF_PWM, pw);
    wr(OFF_DEADBAND, db);
    wr(OFF_RELOAD, rl);
    wr(OFF_CTRL_FIRST, c0 | 32'h0000_0001);
  endtask
  task automatic waitEv;
    int n0;
    n0 = nEv;
    for (int k = 0; k < 400 && nEv == n0; k++) @(posedge clk);
    if (nEv == n0) tout;
  endtask

  // dbSel: 0 no dead band, 1 random, 2 largest value that still leaves each output a pulse (lim)
  task automatic pwmRun(input logic [3:0] m, input logic pol, input int dbSel);
    int p, rl, pw, db, lim, t0, base, ho, hc, hb;
    logic dual;
    dual = m == MODE_PWM_DUAL;
    p = $urandom_range(1, 3);
    rl = $urandom_range(12, 40);
    pw = $urandom_range(4, rl - 4);
    lim = (pw < rl - pw ? pw : rl - pw) * p - 1;
    db = dbSel == 0 ? 0 : dbSel == 2 ? lim : $urandom_range(0, lim);
    cfg(m, pol, p, rl - 2, pw, db, rl, INT_SRC_BOTH);
    waitEv;
    t0 = cyc;
    waitEv;
    chk(cyc - t0, rl * p);
    base = pol ? pw * p : (rl - pw) * p;
    if (dual) base = base - db;
    ho = 0; hc = 0; hb = 0;
    repeat (2 * rl * p) begin
      @(posedge clk);
      #1;
      ho += timerOut === 1'b1;
      hc += timerOutComp === 1'b1;
      hb += timerOut === 1'b1 && timerOutComp === 1'b1;
    end
    chk(ho, 2 * base);
    chk(hc, dual ? 2 * (rl * p - base - 2 * db) : 0);
    chk(hb, 0);
    chk(pinIsOutput, dual);
  endtask

  task automatic capRun(input logic [1:0] src);
    logic pol;
    logic [31:0] c1, c2, v, f;
    int n0;
    pol = $urandom_range(0, 1);
    @(posedge clk);
    pinLevel <= pol;
    cfg(MODE_CAPTURE, pol, 1, 1, 0, 0, 200, src);
    chk(pinIsOutput, 0);
    rd(OFF_COUNT, c1);
    n0 = nEv;
    @(posedge clk);
    pinLevel <= !pol;
    repeat (8) @(posedge clk);
    chk(nEv - n0, 0);
    rd(OFF_PWM, v);
    chk(v, 0);
    pinLevel <= pol;
    repeat (8) @(posedge clk);
    chk(nEv - n0, src != INT_SRC_RELOAD);
    rd(OFF_PWM, v);
    rd(OFF_COUNT, c2);
    rd(OFF_CTRL_FIRST, f);
    chk(v >= c1 && c2 > v, 1);
    chk(f[BIT_CAPTURE_FLAG], 1);
    n0 = nEv;
    repeat (250) @(posedge clk);
    chk(nEv - n0, src != INT_SRC_CAPTURE);
    rd(OFF_CTRL_FIRST, f);
    chk(f[BIT_CAPTURE_FLAG], 0);
  endtask

  initial begin
    logic [7:0] ra[5];
    logic [31:0] rv[5];
    logic [31:0] d;
    logic [1:0] r;
    ra = '{OFF_CTRL_FIRST, OFF_COUNT, OFF_RELOAD, OFF_PWM, OFF_STATUS};
    rv = '{32'h0, {16'h0, COUNT_RESET}, {16'h0, RELOAD_RESET}, {16'h0, PWM_RESET}, 32'h0};
    void'($urandom(28686));
    repeat (4) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 5; i++) begin
      rd(ra[i], d);
      chk(d, rv[i]);
    end
    axw(8'h1C, 32'h0000_00FF, r);
    chk(r, RESP_SLVERR);
    axr(8'h1C, d, r);
    chk(d, 32'h0000_0000);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    axw(OFF_CTRL_FIRST, 32'h0000_0080, r);
    rd(OFF_CTRL_FIRST, d);
    chk(d, 0);
    wr(OFF_DEADBAND, 32'h0000_00FF);
    rd(OFF_DEADBAND, d);
    chk(d, {24'h0, DEADBAND_MAX});
    pwmRun(MODE_PWM_SINGLE, 0, 1);
    pwmRun(MODE_PWM_SINGLE, 1, 1);
    pwmRun(MODE_PWM_DUAL, 0, 0);
    pwmRun(MODE_PWM_DUAL, 1, 2);
    pwmRun(MODE_PWM_DUAL, $urandom_range(0, 1), 1);
    capRun(INT_SRC_BOTH);
    capRun(INT_SRC_CAPTURE);
    capRun(INT_SRC_RELOAD);
    conclude;
  end
endmodule
`default_nettype wire
